/* File: common/cc_timer_defs.vh */
// Constants for the 16-bit capture/compare timer: register addresses, field positions and reset values.
// Assumes it is included by the timer design file and the test files, by its bare name.
// Functional notes
// - Counter is 16 bits, read only, advancing once per selected count clock.
// - Reading the running counter holds off one count so a stable snapshot returns.
// - Counter returns to zero on reset and whenever mode select is stop.
// - In clear-on-edge mode a valid primary input edge clears and restarts counting.
// - In clear-on-match mode the counter clears on the count tick after it equals the first register.
// - In one-shot mode the soft trigger bit or a primary edge clears the counter.
// - Control bit 0 picks compare (0) or capture (1) for the first register.
// - First register in compare mode raises the first match interrupt on equality.
// - First register in capture mode latches the count on a selected input edge.
// - Primary edge select: 00 fall/rise, 01 rise/fall, 10 prohibited, 11 both/no capture.
// - Secondary input captures on its own valid edge; 00 fall, 01 rise, 11 both.
// - First register is written only by word accesses and is undefined after reset.
// - Control bit 2 picks compare (0) or capture (1) for the second register.
// - Second register in compare mode raises the second match interrupt on equality.
// - Second register in capture mode latches the count on the primary valid edge.
// - Second register is written only by word accesses and is undefined after reset.
// - Counter stays stopped at mode 00 and starts on any other mode value.
// - Capture source bit: 0 secondary valid edge, 1 opposite of primary valid edge.
`ifndef CC_TIMER_DEFS_VH
`define CC_TIMER_DEFS_VH
`define ADDR_COUNT_VALUE 16'hFF10
`define ADDR_CAPCMP_FIRST 16'hFF12
`define ADDR_CAPCMP_SECOND 16'hFF14
`define ADDR_CAPCMP_CONTROL 16'hFF16
`define ADDR_TIMER_MODE_CONTROL 16'hFF18
`define ADDR_TIMER_OUTPUT_CONTROL 16'hFF1A
`define ADDR_PRESCALER_EDGE_CONFIG 16'hFF1C
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define COUNT_MAX 16'hFFFF
`define COUNT_ONE 16'h0001
`define TMC_OVF_BIT 0
`define TMC_TIMING_BIT 1
`define TMC_MODE_LO 2
`define TMC_MODE_HI 3
`define TMC_MASK 8'h0F
`define MODE_STOP 2'h0
`define MODE_FREE 2'h1
`define MODE_CLR_EDGE 2'h2
`define MODE_CLR_MATCH 2'h3
`define CRC_FIRST_MODE_BIT 0
`define CRC_FIRST_SRC_BIT 1
`define CRC_SECOND_MODE_BIT 2
`define CRC_MASK 8'h07
`define TOC_ONESHOT_SOFT_TRIGGER_BIT 6
`define TOC_OSPE_BIT 5
`define TOC_MASK 8'h3F
`define PRM_PRI_ES_LO 4
`define PRM_PRI_ES_HI 5
`define PRM_SEC_ES_LO 6
`define PRM_SEC_ES_HI 7
`define ES_FALL 2'h0
`define ES_RISE 2'h1
`define ES_BAD 2'h2
`define ES_BOTH 2'h3
`endif

/* File: rtl/cc_timer.v */
// Sixteen-bit capture/compare timer: counter, two capture/compare registers and control registers.
// Assumes count_tick is a one-cycle pulse from prescaler logic on mclk, at most every second cycle,
// and that the CPU memory port is synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
`include "cc_timer_defs.vh"
module cc_timer #(
  parameter AW = 16,
  parameter CW = 16
) (
  input wire mclk,
  input wire reset_n,
  input wire count_tick,
  input wire primary_timer_input,
  input wire secondary_timer_input,
  input wire [AW-1:0] addr,
  input wire wr_en,
  input wire wr_word,
  input wire rd_en,
  input wire [15:0] wdata,
  output reg [15:0] rd_data_r,
  output reg first_match_irq_r,
  output reg second_match_irq_r,
  output reg running_r
);
  reg [CW-1:0] count_value_r;
  reg [CW-1:0] count_value_nxt;
  reg [CW-1:0] capture_compare_first_r;
  reg [CW-1:0] capture_compare_second_r;
  reg [7:0] timer_mode_control_r;
  reg [7:0] capcmp_control_r;
  reg [7:0] timer_output_control_r;
  reg [7:0] prescaler_edge_config_r;
  reg oneshot_soft_trigger_r;
  reg tick_pending_r;
  reg cmp_arm_r;
  reg stepped;
  reg wrap;
  reg [15:0] rd_nxt;

  wire pri_rise;
  wire pri_fall;
  wire sec_rise;
  wire sec_fall;

  pin_edge_sense u_pri (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin(primary_timer_input),
    .rise_r(pri_rise),
    .fall_r(pri_fall)
  );

  pin_edge_sense u_sec (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin(secondary_timer_input),
    .rise_r(sec_rise),
    .fall_r(sec_fall)
  );

  // Valid edge for a two-bit edge select; the prohibited code matches nothing.
  function edge_valid;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      case (sel)
        `ES_FALL: edge_valid = fall;
        `ES_RISE: edge_valid = rise;
        `ES_BOTH: edge_valid = rise | fall;
        default: edge_valid = 1'b0;
      endcase
    end
  endfunction

  // Capture edge opposite to the valid edge; both-edge select gives no capture.
  function edge_reverse;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      case (sel)
        `ES_FALL: edge_reverse = rise;
        `ES_RISE: edge_reverse = fall;
        default: edge_reverse = 1'b0;
      endcase
    end
  endfunction

  function addr_hit;
    input [AW-1:0] a;
    input [15:0] target;
    begin
      addr_hit = (a == target[AW-1:0]);
    end
  endfunction

  wire [1:0] op_mode = {timer_mode_control_r[`TMC_MODE_HI], timer_mode_control_r[`TMC_MODE_LO]};
  wire [1:0] pri_es = {prescaler_edge_config_r[`PRM_PRI_ES_HI], prescaler_edge_config_r[`PRM_PRI_ES_LO]};
  wire [1:0] sec_es = {prescaler_edge_config_r[`PRM_SEC_ES_HI], prescaler_edge_config_r[`PRM_SEC_ES_LO]};
  wire is_running = (op_mode != `MODE_STOP);
  wire oneshot_mode = timer_output_control_r[`TOC_OSPE_BIT];
  wire first_capture = capcmp_control_r[`CRC_FIRST_MODE_BIT];
  wire second_capture = capcmp_control_r[`CRC_SECOND_MODE_BIT];

  wire pri_valid = edge_valid(pri_es, pri_rise, pri_fall);
  wire pri_reverse = edge_reverse(pri_es, pri_rise, pri_fall);
  wire sec_valid = edge_valid(sec_es, sec_rise, sec_fall);

  wire wr_tmc = wr_en & addr_hit(addr, `ADDR_TIMER_MODE_CONTROL);
  wire wr_crc = wr_en & addr_hit(addr, `ADDR_CAPCMP_CONTROL);
  wire wr_toc = wr_en & addr_hit(addr, `ADDR_TIMER_OUTPUT_CONTROL);
  wire wr_prm = wr_en & addr_hit(addr, `ADDR_PRESCALER_EDGE_CONFIG);
  wire wr_first = wr_en & wr_word & addr_hit(addr, `ADDR_CAPCMP_FIRST);
  wire wr_second = wr_en & wr_word & addr_hit(addr, `ADDR_CAPCMP_SECOND);
  wire rd_count = rd_en & addr_hit(addr, `ADDR_COUNT_VALUE);

  // A count that lands on a read cycle is deferred one cycle, so the read sees a settled value.
  wire tick_any = count_tick | tick_pending_r;
  wire tick_now = tick_any & ~rd_count & is_running;

  wire clr_edge = (op_mode == `MODE_CLR_EDGE) & pri_valid;
  wire clr_match = (op_mode == `MODE_CLR_MATCH) & (count_value_r == capture_compare_first_r);
  wire clr_oneshot = oneshot_mode & (oneshot_soft_trigger_r | pri_valid);

  wire first_cap_event = first_capture &
    (capcmp_control_r[`CRC_FIRST_SRC_BIT] ? pri_reverse : sec_valid);
  wire second_cap_event = second_capture & pri_valid;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_pending_r <= 1'b0;
    end else begin
      tick_pending_r <= tick_any & rd_count & is_running;
    end
  end

  always @* begin
    count_value_nxt = count_value_r;
    stepped = 1'b0;
    wrap = 1'b0;
    if (!is_running) begin
      count_value_nxt = `RST_WORD;
    end else if (is_running && (clr_edge || clr_oneshot)) begin
      count_value_nxt = `RST_WORD;
    end else if (tick_now) begin
      stepped = 1'b1;
      wrap = (count_value_r == `COUNT_MAX);
      if (clr_match) begin
        count_value_nxt = `RST_WORD;
      end else begin
        count_value_nxt = count_value_r + `COUNT_ONE;
      end
    end
  end

  // Stop holds the counter at zero; any other mode lets it run from the next tick.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_value_r <= `RST_WORD;
      running_r <= 1'b0;
    end else begin
      count_value_r <= count_value_nxt;
      running_r <= is_running;
    end
  end

  // The compare is armed only by a count step, so a held count cannot repeat the interrupt.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_arm_r <= 1'b0;
      first_match_irq_r <= 1'b0;
      second_match_irq_r <= 1'b0;
    end else begin
      cmp_arm_r <= stepped;
      first_match_irq_r <= cmp_arm_r & is_running & ~first_capture &
        (count_value_r == capture_compare_first_r);
      second_match_irq_r <= cmp_arm_r & is_running & ~second_capture &
        (count_value_r == capture_compare_second_r);
    end
  end

  // No reset here: the capture/compare contents are undefined until software loads them.
  always @(posedge mclk) begin
    if (first_cap_event) begin
      capture_compare_first_r <= count_value_r;
    end else if (wr_first) begin
      capture_compare_first_r <= wdata[CW-1:0];
    end
    if (second_cap_event) begin
      capture_compare_second_r <= count_value_r;
    end else if (wr_second) begin
      capture_compare_second_r <= wdata[CW-1:0];
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timer_mode_control_r <= `RST_BYTE;
      capcmp_control_r <= `RST_BYTE;
      timer_output_control_r <= `RST_BYTE;
      prescaler_edge_config_r <= `RST_BYTE;
      oneshot_soft_trigger_r <= 1'b0;
    end else begin
      if (wr_tmc) begin
        timer_mode_control_r[`TMC_MODE_HI:`TMC_TIMING_BIT] <=
          wdata[`TMC_MODE_HI:`TMC_TIMING_BIT];
      end
      // The overflow flag is set by a wrap; a wrap in the clearing cycle wins over the write of zero.
      if (stepped && wrap) begin
        timer_mode_control_r[`TMC_OVF_BIT] <= 1'b1;
      end else if (wr_tmc) begin
        timer_mode_control_r[`TMC_OVF_BIT] <= wdata[`TMC_OVF_BIT];
      end
      if (wr_crc) begin
        capcmp_control_r <= wdata[7:0] & `CRC_MASK;
      end
      if (wr_toc) begin
        timer_output_control_r <= wdata[7:0] & `TOC_MASK;
      end
      oneshot_soft_trigger_r <= wr_toc & wdata[`TOC_ONESHOT_SOFT_TRIGGER_BIT];
      if (wr_prm) begin
        prescaler_edge_config_r <= wdata[7:0];
      end
    end
  end

  // Reads return the count as it stands; the trigger bit always reads zero.
  always @* begin
    rd_nxt = `RST_WORD;
    case (1'b1)
      addr_hit(addr, `ADDR_COUNT_VALUE): rd_nxt = count_value_r;
      addr_hit(addr, `ADDR_CAPCMP_FIRST): rd_nxt = capture_compare_first_r;
      addr_hit(addr, `ADDR_CAPCMP_SECOND): rd_nxt = capture_compare_second_r;
      addr_hit(addr, `ADDR_CAPCMP_CONTROL): rd_nxt = {8'h00, capcmp_control_r};
      addr_hit(addr, `ADDR_TIMER_MODE_CONTROL): rd_nxt = {8'h00, timer_mode_control_r & `TMC_MASK};
      addr_hit(addr, `ADDR_TIMER_OUTPUT_CONTROL): rd_nxt = {8'h00, timer_output_control_r};
      addr_hit(addr, `ADDR_PRESCALER_EDGE_CONFIG): rd_nxt = {8'h00, prescaler_edge_config_r};
      default: rd_nxt = `RST_WORD;
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= `RST_WORD;
    end else if (rd_en) begin
      rd_data_r <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pin_edge_sense.v */
// Synchroniser and edge detector for one timer input pin.
// Assumes the pin is asynchronous to mclk; outputs are one-cycle pulses in the mclk domain.
`timescale 1ns/10ps
`default_nettype none
module pin_edge_sense (
  input wire mclk,
  input wire reset_n,
  input wire pin,
  output reg rise_r,
  output reg fall_r
);
  reg meta_r;
  reg sync_r;
  reg hist_r;

  // The first stage feeds only the second stage, so no logic sees a metastable level.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      hist_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      hist_r <= sync_r;
      rise_r <= sync_r & ~hist_r;
      fall_r <= ~sync_r & hist_r;
    end
  end
endmodule
`default_nettype wire

/* File: test/cc_timer_props.sv */
// Assertion checker for the capture/compare timer, watching its top-level ports only.
// Assumes the timer constants header is on the include path; attached by the bind below.
`timescale 1ns/10ps
`default_nettype none
`include "cc_timer_defs.vh"
module cc_timer_props #(
  parameter AW = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic count_tick,
  input wire logic [AW-1:0] addr,
  input wire logic wr_en,
  input wire logic wr_word,
  input wire logic rd_en,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rd_data_r,
  input wire logic first_match_irq_r,
  input wire logic second_match_irq_r,
  input wire logic running_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_first_irq_pulse: assert property (first_match_irq_r |=> !first_match_irq_r)
    else $error("first match pulse too long");
  a_second_irq_pulse: assert property (second_match_irq_r |=> !second_match_irq_r)
    else $error("second match pulse too long");
  // Three quiet cycles cover a tick that was already in flight when stop was written.
  a_stop_no_irq: assert property (!running_r [*3] |-> !(first_match_irq_r || second_match_irq_r))
    else $error("match pulse while stopped");
  a_irq_after_tick: assert property ((first_match_irq_r || second_match_irq_r) |->
    ($past(count_tick, 2) || $past(count_tick, 3)))
    else $error("match pulse without a count");
  a_mode_runs: assert property (wr_en && addr == `ADDR_TIMER_MODE_CONTROL |-> ##2
    running_r == $past(wdata[`TMC_MODE_HI] | wdata[`TMC_MODE_LO], 2))
    else $error("run state does not follow mode");
  a_stop_reads_zero: assert property (rd_en && addr == `ADDR_COUNT_VALUE && !running_r &&
    !$past(running_r) |=> rd_data_r == 16'h0000)
    else $error("stopped count not zero");
  a_read_holds: assert property (!rd_en |=> $stable(rd_data_r))
    else $error("read data moved without a read");
  a_word_readback: assert property ((wr_en && wr_word && addr == `ADDR_CAPCMP_FIRST) ##2
    (rd_en && addr == `ADDR_CAPCMP_FIRST) |=> rd_data_r == $past(wdata, 3))
    else $error("first register readback wrong");
endmodule
bind cc_timer cc_timer_props #(.AW(AW)) u_props (.mclk(mclk), .reset_n(reset_n), .count_tick(count_tick),
  .addr(addr), .wr_en(wr_en), .wr_word(wr_word), .rd_en(rd_en), .wdata(wdata), .rd_data_r(rd_data_r),
  .first_match_irq_r(first_match_irq_r), .second_match_irq_r(second_match_irq_r), .running_r(running_r));
`default_nettype wire

/* File: test/tb_cc_timer.sv */
// Self-checking bench for the capture/compare timer: register tasks, count ticks and pin edges.
// Assumes the timer sources, its constants header and the pin source model are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
`include "cc_timer_defs.vh"
module tb_cc_timer;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic count_tick = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic wr_word = 1'b0;
  logic rd_en = 1'b0;
  wire logic [15:0] rd_data_r;
  wire logic irq1, irq2, running_r, pri_pin, sec_pin;
  int num_errors = 0;
  int n_tests = 0;
  int irq1_n = 0;
  int irq2_n = 0;
  always #25 mclk = ~mclk;
  timer_pin_source i_pins (.mclk(mclk), .primary_timer_input(pri_pin), .secondary_timer_input(sec_pin));
  cc_timer i_dut (.mclk(mclk), .reset_n(reset_n), .count_tick(count_tick), .primary_timer_input(pri_pin),
    .secondary_timer_input(sec_pin), .addr(addr), .wr_en(wr_en), .wr_word(wr_word), .rd_en(rd_en),
    .wdata(wdata), .rd_data_r(rd_data_r), .first_match_irq_r(irq1), .second_match_irq_r(irq2),
    .running_r(running_r));
  always @(posedge mclk) begin
    if (irq1 === 1'b1) irq1_n <= irq1_n + 1;
    if (irq2 === 1'b1) irq2_n <= irq2_n + 1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_word <= w;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 chk(rd_data_r, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      count_tick <= 1'b1;
      @(posedge mclk);
      count_tick <= 1'b0;
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`ADDR_COUNT_VALUE, 16'h0000);
    rd(`ADDR_TIMER_MODE_CONTROL, 16'h0000);
    rd(16'hFF1E, 16'h0000);
    wr(`ADDR_CAPCMP_FIRST, 16'h0003, 1'b1);
    rd(`ADDR_CAPCMP_FIRST, 16'h0003);
    wr(`ADDR_CAPCMP_SECOND, 16'h0005, 1'b1);
    wr(`ADDR_CAPCMP_FIRST, 16'h00AA, 1'b0);
    rd(`ADDR_CAPCMP_FIRST, 16'h0003);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0004, 1'b0);
    tick(5);
    rd(`ADDR_COUNT_VALUE, 16'h0005);
    chk({15'h0000, running_r}, 16'h0001);
    chk(16'(irq1_n), 16'h0001);
    chk(16'(irq2_n), 16'h0001);
    // A tick landing on a count read must be deferred, not lost.
    @(posedge mclk);
    count_tick <= 1'b1;
    addr <= `ADDR_COUNT_VALUE;
    rd_en <= 1'b1;
    @(posedge mclk);
    count_tick <= 1'b0;
    rd_en <= 1'b0;
    #1 chk(rd_data_r, 16'h0005);
    rd(`ADDR_COUNT_VALUE, 16'h0006);
    wr(`ADDR_COUNT_VALUE, 16'h1234, 1'b1);
    rd(`ADDR_COUNT_VALUE, 16'h0006);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0000, 1'b0);
    tick(2);
    rd(`ADDR_COUNT_VALUE, 16'h0000);
    chk({15'h0000, running_r}, 16'h0000);
    wr(`ADDR_CAPCMP_FIRST, 16'h0002, 1'b1);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h000C, 1'b0);
    tick(3);
    rd(`ADDR_COUNT_VALUE, 16'h0000);
    chk(16'(irq1_n), 16'h0002);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0000, 1'b0);
    wr(`ADDR_PRESCALER_EDGE_CONFIG, 16'h0010, 1'b0);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0008, 1'b0);
    tick(4);
    i_pins.drive(1'b0, 1'b1);
    rd(`ADDR_COUNT_VALUE, 16'h0000);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0000, 1'b0);
    i_pins.drive(1'b0, 1'b0);
    wr(`ADDR_CAPCMP_CONTROL, 16'h0005, 1'b0);
    wr(`ADDR_PRESCALER_EDGE_CONFIG, 16'h0050, 1'b0);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0004, 1'b0);
    tick(6);
    i_pins.drive(1'b1, 1'b1);
    tick(1);
    i_pins.drive(1'b0, 1'b1);
    rd(`ADDR_CAPCMP_FIRST, 16'h0006);
    rd(`ADDR_CAPCMP_SECOND, 16'h0007);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0000, 1'b0);
    wr(`ADDR_CAPCMP_CONTROL, 16'h0003, 1'b0);
    wr(`ADDR_PRESCALER_EDGE_CONFIG, 16'h0000, 1'b0);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0004, 1'b0);
    tick(2);
    i_pins.drive(1'b0, 1'b0);
    tick(1);
    i_pins.drive(1'b0, 1'b1);
    rd(`ADDR_CAPCMP_FIRST, 16'h0003);
    wr(`ADDR_PRESCALER_EDGE_CONFIG, 16'h0030, 1'b0);
    tick(1);
    i_pins.drive(1'b0, 1'b0);
    rd(`ADDR_CAPCMP_FIRST, 16'h0003);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0000, 1'b0);
    wr(`ADDR_TIMER_OUTPUT_CONTROL, 16'h0020, 1'b0);
    wr(`ADDR_TIMER_MODE_CONTROL, 16'h0004, 1'b0);
    tick(3);
    wr(`ADDR_TIMER_OUTPUT_CONTROL, 16'h0060, 1'b0);
    rd(`ADDR_COUNT_VALUE, 16'h0000);
    // A primary edge must clear the count in one-shot mode as well as the soft trigger.
    tick(2);
    i_pins.drive(1'b0, 1'b1);
    rd(`ADDR_COUNT_VALUE, 16'h0000);
    conclude;
  end
endmodule
`default_nettype wire

/* File: test/timer_pin_source.sv */
// Behavioural source for the two timer input pins.
// Assumes mclk is the timer clock; the pins are always driven, never released.
`timescale 1ns/10ps
`default_nettype none
module timer_pin_source (
  input wire logic mclk,
  output logic primary_timer_input,
  output logic secondary_timer_input
);
  initial begin
    primary_timer_input = 1'b0;
    secondary_timer_input = 1'b0;
  end
  // Six cycles let the synchroniser, the edge history and the acting edge all see the level.
  task automatic drive(input logic sec, input logic lvl);
    @(posedge mclk);
    if (sec) secondary_timer_input <= lvl;
    else primary_timer_input <= lvl;
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire
